/* File: core/eeprom_end.sv */
// Memory end: two-wire slave with 256-byte array and paged writes
// Function
// R1: Data falling while clock high is start.
// R2: Data rising while clock high is stop.
// R3: Controller changes data only while clock low.
// R4: Sample on rise, drive after fall, open-drain.
// R5: Bytes MSB first; acknowledge low on ninth clock.
// R6: Controller recovers with nine clocks, then start; ctrl_end stops clocking early once data reads high.
// R7: Address word opens with type code 1010.
// R8: Next three bits must match strap pins.
// R9: Unconnected strap pins read as low.
// R10: Last address bit selects read or write.
// R11: Match acknowledges; mismatch returns to standby.
// R12: Write-protect high blocks every array write.
// R13: Byte write, then stop starts timed write.
// R14: During timed write ignore inputs entirely.
// R15: Page write accepts up to 16 bytes.
// R16: Write address wraps inside its page.
// R17: Polling acknowledged only after write completes.
// R18: Counter holds last address plus one.
// R19: Read address wraps from top to zero.
// R20: Current read sends byte at counter.
// R21: Random read: dummy write, restart, read.
// R22: Controller acknowledge continues sequential read.
`timescale 1ns/100ps
module eeprom_end #(
  parameter int WRITE_CYCLES = twe_pkg::SELF_TIMED_WRITE_CYCLES,
  parameter int PAGE_BITS = twe_pkg::PAGE_LOW_BITS
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link
  twe_if.dev link,
  // Straps and protection
  input wire logic [2:0] chip_select_straps_i,
  input wire logic write_protect_i,
  // Status
  output logic busy_o
);

  localparam int PAGE_SIZE = 1 << PAGE_BITS;

  generate
    if (WRITE_CYCLES < 1 || PAGE_BITS < 1 || PAGE_BITS > 7) begin : g_bad
      $error("eeprom_end: unsupported parameter values");
    end
  endgenerate

  // Pin synchronisers
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [2:0] cs_m;
  logic [2:0] cs_q;
  logic wp_m;
  logic wp_q;
  logic scl_p;
  logic sda_p;

  // Protocol state
  twe_pkg::dev_state_t state;
  twe_pkg::word_kind_t kind;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] addr;
  logic rw;
  logic sda_low;
  logic ack_seen;
  logic [PAGE_SIZE-1:0] pend;
  logic [7-PAGE_BITS:0] page;
  logic [31:0] wcnt;

  // Storage
  logic [7:0] mem [0:255];
  logic [7:0] pbuf [0:PAGE_SIZE-1];

  wire scl_q = scl_s[1];
  wire sda_q = sda_s[1];
  wire scl_rise = scl_q & ~scl_p;
  wire scl_fall = ~scl_q & scl_p;
  wire start_det = scl_q & scl_p & sda_p & ~sda_q; // [R1]
  wire stop_det = scl_q & scl_p & ~sda_p & sda_q; // [R2]
  wire byte_done = scl_fall & (cnt == 4'h8);
  wire type_ok =
    shreg[twe_pkg::DEV_TYPE_MSB:twe_pkg::DEV_TYPE_LSB] ==
    twe_pkg::DEV_TYPE_CODE; // [R7]
  wire sel_ok =
    shreg[twe_pkg::DEV_SEL_MSB:twe_pkg::DEV_SEL_LSB] == cs_q; // [R8]
  wire dev_match = type_ok & sel_ok;
  wire [7:0] rd_byte = mem[addr];
  wire [PAGE_BITS-1:0] addr_lo = addr[PAGE_BITS-1:0];
  wire [PAGE_BITS-1:0] addr_lo_inc = addr_lo + 1'b1;
  wire buf_we = (state == twe_pkg::D_RX) & (kind == twe_pkg::K_DATA) &
    byte_done & ~start_det & ~stop_det & ~wp_q; // [R12]
  wire write_done = (state == twe_pkg::D_BUSY) &
    (wcnt == 32'(WRITE_CYCLES - 1));
  wire ack_next = (state == twe_pkg::D_RACK) & scl_fall & ack_seen;
  wire load_tx = ((state == twe_pkg::D_ACK) & scl_fall &
    (kind == twe_pkg::K_DEV) & rw) | ack_next;

  // Open-drain data: only ever pull low or release
  assign link.dev_sda_o = 1'b0; // [R4]
  assign link.dev_sda_oe_n = ~sda_low; // [R4]
  assign busy_o = (state == twe_pkg::D_BUSY);

  // Two flops on every pin; first stage read only by the second
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      cs_m <= 3'h0;
      cs_q <= 3'h0;
      wp_m <= 1'b0;
      wp_q <= 1'b0;
    end else if (ce_i) begin
      scl_s <= {scl_s[0], link.scl};
      sda_s <= {sda_s[0], link.sda};
      scl_p <= scl_q;
      sda_p <= sda_q;
      // An open strap pin resolves low at the pad
      cs_m <= chip_select_straps_i; // [R9]
      cs_q <= cs_m;
      wp_m <= write_protect_i;
      wp_q <= wp_m;
    end
  end

  // Nonvolatile array has no reset; the pending bytes of one page commit at once
  always_ff @(posedge mclk_i) begin
    if (ce_i && write_done) begin
      for (int i = 0; i < PAGE_SIZE; i++) begin
        if (pend[i]) begin
          mem[{page, PAGE_BITS'(i)}] <= pbuf[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i && buf_we) begin
      pbuf[addr_lo] <= shreg; // [R15]
    end
  end

  // Self-timed write counter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wcnt <= 32'h0;
    end else if (ce_i) begin
      if (state != twe_pkg::D_BUSY || write_done) begin
        wcnt <= 32'h0;
      end else begin
        wcnt <= wcnt + 32'h1; // [R13]
      end
    end
  end

  // Protocol engine
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= twe_pkg::D_IDLE; // [R2]
      kind <= twe_pkg::K_DEV;
      cnt <= 4'h0;
      shreg <= 8'h00;
      addr <= twe_pkg::ADDR_RESET;
      rw <= 1'b0;
      sda_low <= 1'b0;
      ack_seen <= 1'b0;
      pend <= '0;
      page <= '0;
    end else if (ce_i) begin
      if (state == twe_pkg::D_BUSY) begin
        // Deaf to the link until the commit; polls get no acknowledge
        sda_low <= 1'b0; // [R14] [R17]
        if (write_done) begin
          pend <= '0;
          state <= twe_pkg::D_IDLE;
        end
      end else if (start_det) begin
        // Restart also serves the random read
        state <= twe_pkg::D_RX; // [R1] [R21]
        kind <= twe_pkg::K_DEV;
        cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (stop_det) begin
        sda_low <= 1'b0;
        // Pending page bytes start the timed write, else standby
        state <= (|pend) ? twe_pkg::D_BUSY : twe_pkg::D_IDLE; // [R13] [R2]
      end else if (load_tx) begin
        // Byte at the counter, counter then points past it
        state <= twe_pkg::D_TX; // [R20] [R22]
        shreg <= rd_byte;
        sda_low <= ~rd_byte[7]; // [R5]
        addr <= addr + 8'h01; // [R18] [R19]
        cnt <= 4'h0;
      end else begin
        case (state)
          twe_pkg::D_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_q}; // [R4] [R5]
              cnt <= cnt + 4'h1;
            end else if (byte_done) begin
              case (kind)
                twe_pkg::K_DEV: begin
                  if (dev_match) begin
                    rw <= shreg[twe_pkg::DEV_RW_BIT]; // [R10]
                    sda_low <= 1'b1; // [R11]
                    state <= twe_pkg::D_ACK;
                  end else begin
                    state <= twe_pkg::D_IDLE; // [R11]
                  end
                end
                twe_pkg::K_WADDR: begin
                  addr <= shreg; // [R13]
                  sda_low <= 1'b1; // [R5]
                  state <= twe_pkg::D_ACK;
                end
                default: begin
                  // Protected bytes are still acknowledged, never stored
                  if (!wp_q) begin
                    pend[addr_lo] <= 1'b1; // [R12]
                    page <= addr[7:PAGE_BITS];
                  end
                  addr <= {addr[7:PAGE_BITS], addr_lo_inc}; // [R16] [R18]
                  sda_low <= 1'b1; // [R15]
                  state <= twe_pkg::D_ACK;
                end
              endcase
            end
          end
          twe_pkg::D_ACK: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
              cnt <= 4'h0;
              state <= twe_pkg::D_RX;
              kind <= (kind == twe_pkg::K_DEV) ? twe_pkg::K_WADDR :
                twe_pkg::K_DATA;
            end
          end
          twe_pkg::D_TX: begin
            if (scl_fall) begin
              if (cnt == 4'h7) begin
                sda_low <= 1'b0;
                state <= twe_pkg::D_RACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_low <= ~shreg[6]; // [R4]
                cnt <= cnt + 4'h1;
              end
            end
          end
          twe_pkg::D_RACK: begin
            if (scl_rise) begin
              ack_seen <= ~sda_q; // [R22]
            end else if (scl_fall) begin
              // No acknowledge: stand by for the stop
              state <= twe_pkg::D_IDLE; // [R20] [R22]
            end
          end
          default: begin
            sda_low <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : eeprom_end

/* File: core/twe_pkg.sv */
// Shared constants and types for the two-wire memory link
package twe_pkg;

  // Core clock
  localparam int MCLK_MHZ = 250;
  localparam int MCLK_PERIOD_NS = 4;

  // Self-timed write: longest time, rounded down to whole cycles
  localparam int SELF_TIMED_WRITE_TIME_US = 3000;
  localparam int SELF_TIMED_WRITE_CYCLES = SELF_TIMED_WRITE_TIME_US * MCLK_MHZ;

  // Serial clock made by the controller; a quarter is a least time
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYCLES =
    (SCL_PERIOD_NS / 4 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // Word and array geometry
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 8;
  localparam int PAGE_LOW_BITS = 4;
  localparam int RECOVER_CLOCKS = 9;

  // Device address word layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_SEL_MSB = 3;
  localparam int DEV_SEL_LSB = 1;
  localparam int DEV_RW_BIT = 0;

  // Reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX   = 3'b001,
    D_ACK  = 3'b010,
    D_TX   = 3'b011,
    D_RACK = 3'b100,
    D_BUSY = 3'b101
  } dev_state_t;

  typedef enum logic [1:0] {
    K_DEV   = 2'b00,
    K_WADDR = 2'b01,
    K_DATA  = 2'b10
  } word_kind_t;

  typedef enum logic [2:0] {
    CMD_START   = 3'b000,
    CMD_STOP    = 3'b001,
    CMD_WRITE   = 3'b010,
    CMD_READ    = 3'b011,
    CMD_RECOVER = 3'b100
  } cmd_t;

endpackage : twe_pkg

/* File: core/twe_if.sv */
// Two-wire link between memory end and controller end
`timescale 1ns/100ps
interface twe_if;
  logic scl;
  logic ctrl_sda_o;
  logic ctrl_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Wired-AND with pull-up: any enabled low driver wins
  assign sda = (ctrl_sda_oe_n | ctrl_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );

  modport ctrl (
    output scl,
    output ctrl_sda_o,
    output ctrl_sda_oe_n,
    input sda
  );
endinterface : twe_if

/* File: core/ctrl_end.sv */
// Controller end: makes the serial clock and runs bus primitives
`timescale 1ns/100ps
module ctrl_end #(
  parameter int QUARTER = twe_pkg::SCL_QUARTER_CYCLES
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link
  twe_if.ctrl link,
  // Command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire twe_pkg::cmd_t cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_ack_i,
  // Response
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_ack_o
);

  generate
    if (QUARTER < 2 || QUARTER > 65535) begin : g_bad
      $error("ctrl_end: QUARTER out of range");
    end
  endgenerate

  logic [1:0] sda_s;
  logic busy;
  twe_pkg::cmd_t op;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [15:0] div;
  logic [7:0] shreg;
  logic ack_bit;
  logic ack_r;
  logic scl_r;
  logic sda_low_r;

  wire sda_q = sda_s[1];
  wire tick = busy & (div == 16'(QUARTER - 1));
  wire is_start = (op == twe_pkg::CMD_START);
  wire is_stop = (op == twe_pkg::CMD_STOP);
  wire is_write = (op == twe_pkg::CMD_WRITE);
  wire is_read = (op == twe_pkg::CMD_READ);
  wire is_rec = (op == twe_pkg::CMD_RECOVER);
  wire last_bit = is_rec ?
    (bitn == 4'(twe_pkg::RECOVER_CLOCKS - 1)) | ack_r : (bitn == 4'h8);
  wire finish = tick & (q == 2'h3) & (is_start | is_stop | last_bit);
  wire sample = tick & (q == 2'h2);
  wire next_scl = is_stop ? (q != 2'h0) : (q == 2'h1 || q == 2'h2);
  // Data moves only in quarter 0, clock low; start and stop excepted
  wire next_sda_low =
    is_start ? q[1] : // [R1] [R21]
    is_stop ? ~q[1] : // [R2]
    is_write ? (bitn != 4'h8) & ~shreg[7] : // [R3] [R5]
    is_read ? (bitn == 4'h8) & ack_bit : // [R22] [R20]
    1'b0; // [R6]

  assign cmd_ready_o = ~busy;
  assign link.scl = scl_r;
  assign link.ctrl_sda_o = 1'b0;
  assign link.ctrl_sda_oe_n = ~sda_low_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_s <= 2'h3;
    end else if (ce_i) begin
      sda_s <= {sda_s[0], link.sda};
    end
  end

  // Divider that paces quarters of the serial clock
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 16'h0;
      q <= 2'h0;
    end else if (ce_i) begin
      if (!busy || tick) begin
        div <= 16'h0;
      end else begin
        div <= div + 16'h1;
      end
      if (!busy) begin
        q <= 2'h0;
      end else if (tick) begin
        q <= q + 2'h1;
      end
    end
  end

  // Pins held between commands, so the bus stays where it was left
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_r <= 1'b1;
      sda_low_r <= 1'b0;
    end else if (ce_i && busy) begin
      scl_r <= next_scl;
      sda_low_r <= next_sda_low;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      op <= twe_pkg::CMD_START;
      bitn <= 4'h0;
      shreg <= 8'h00;
      ack_bit <= 1'b0;
      ack_r <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      rsp_ack_o <= 1'b0;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      if (!busy) begin
        if (cmd_valid_i) begin
          busy <= 1'b1;
          op <= cmd_op_i;
          bitn <= 4'h0;
          shreg <= cmd_data_i;
          ack_bit <= cmd_ack_i;
          ack_r <= 1'b0;
        end
      end else if (finish) begin
        busy <= 1'b0;
        rsp_valid_o <= 1'b1;
        rsp_data_o <= shreg;
        rsp_ack_o <= ack_r;
      end else if (sample) begin
        if (is_write && bitn == 4'h8) begin
          ack_r <= ~sda_q; // [R5]
        end else if (is_read && bitn != 4'h8) begin
          shreg <= {shreg[6:0], sda_q};
        end else if (is_rec) begin
          ack_r <= sda_q; // [R6]
        end
      end else if (tick && q == 2'h3) begin
        bitn <= bitn + 4'h1;
        if (is_write) begin
          shreg <= {shreg[6:0], 1'b0};
        end
      end
    end
  end

endmodule : ctrl_end

/* File: testbench/twe_properties.sv */
// Link assertions watching both ends of the two-wire memory bus
`timescale 1ns/100ps
module twe_properties (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic ctrl_sda_o,
  input wire logic ctrl_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  logic [1:0] pins_q;
  logic [3:0] bits;
  logic [7:0] word;
  logic first;
  logic rd;
  wire rise = scl & ~pins_q[1];
  wire fall = ~scl & pins_q[1];
  wire start = scl & pins_q[1] & pins_q[0] & ~sda;
  wire stop = scl & pins_q[1] & ~pins_q[0] & sda;
  wire ninth = rise & (bits == 4'h8);

  // Framing as the memory should see it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_q <= 2'h3;
      bits <= 4'h0;
      word <= 8'h00;
    end else begin
      pins_q <= {scl, sda};
      bits <= (start | ninth) ? 4'h0 : bits + {3'h0, rise};
      word <= (rise & ~ninth) ? {word[6:0], sda} : word;
    end
  end

  // Direction comes from the first word after a start
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      first <= 1'b0;
      rd <= 1'b0;
    end else if (start) begin
      first <= 1'b1;
      rd <= 1'b0;
    end else if (ninth) begin
      first <= 1'b0;
      rd <= first ? word[0] : rd;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence held_low;
    !dev_sda_oe_n [*8];
  endsequence
  sequence let_go;
    ##[1:8] dev_sda_oe_n;
  endsequence

  open_drain_a: assert property (
    !dev_sda_o && !ctrl_sda_o) else $error("data driven high");
  drive_on_low_a: assert property (
    $changed(dev_sda_oe_n) |-> !scl) else $error("drive moved, clock high");
  hold_high_a: assert property (
    rise && !dev_sda_oe_n |-> held_low) else $error("drive dropped early");
  type_code_a: assert property (
    ninth && first && word[7:4] != 4'hA |-> dev_sda_oe_n)
    else $error("foreign type code acknowledged");
  write_quiet_a: assert property (
    rise && !ninth && !rd |-> dev_sda_oe_n) else $error("drove a write bit");
  ctrl_slot_a: assert property (
    ninth && rd && !first |-> dev_sda_oe_n) else $error("drove master slot");
  ack_release_a: assert property (
    fall && bits == 4'h0 && !rd && !dev_sda_oe_n |-> let_go)
    else $error("acknowledge not released");
  stop_free_a: assert property (
    stop |=> dev_sda_oe_n [*8]) else $error("drove after stop");
  // Clock high: only a start or a stop may move the controller's data
  ctrl_quiet_a: assert property (
    $changed(ctrl_sda_oe_n) && scl |-> start || stop)
    else $error("controller data moved, clock high");
endmodule : twe_properties

/* File: testbench/tb_top.sv */
// Bench joining memory end and controller end over one link
`timescale 1ns/100ps
module tb_top;
  localparam logic [2:0] SEL = 3'h5;
  localparam logic [7:0] DEV = 8'hAA;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] straps = SEL;
  logic wp = 1'b0;
  logic cmd_valid = 1'b0;
  twe_pkg::cmd_t cmd_op = twe_pkg::CMD_STOP;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack = 1'b0;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_ack;
  logic busy;
  logic [7:0] rdat;
  logic rack;
  int bad_count = 0;
  int n_compared = 0;

  twe_if link ();
  eeprom_end #(.WRITE_CYCLES(400), .PAGE_BITS(4)) eeprom_end_i (
    .mclk_i(mclk), .rst_i(rst), .ce_i(1'b1), .link(link),
    .chip_select_straps_i(straps), .write_protect_i(wp), .busy_o(busy));
  ctrl_end #(.QUARTER(8)) ctrl_end_i (
    .mclk_i(mclk), .rst_i(rst), .ce_i(1'b1), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(), .cmd_op_i(cmd_op),
    .cmd_data_i(cmd_data), .cmd_ack_i(cmd_ack), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .rsp_ack_o(rsp_ack));
  twe_properties twe_properties_i (
    .mclk_i(mclk), .rst_i(rst), .scl(link.scl), .sda(link.sda),
    .ctrl_sda_o(link.ctrl_sda_o), .ctrl_sda_oe_n(link.ctrl_sda_oe_n),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic complete_run;
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Only called when idle, so the command is taken at the second edge
  task automatic cmd(input twe_pkg::cmd_t op, input logic [7:0] d,
      input logic a);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_ack <= a;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 400);
    rdat = rsp_data;
    rack = rsp_ack;
    if (n >= 400) begin
      bad_count++;
      complete_run();
    end
  endtask : cmd

  task automatic bus_start;
    cmd(twe_pkg::CMD_START, 8'h00, 1'b0);
  endtask : bus_start

  task automatic bus_stop;
    cmd(twe_pkg::CMD_STOP, 8'h00, 1'b0);
  endtask : bus_stop

  task automatic send(input logic [7:0] d, input logic e);
    cmd(twe_pkg::CMD_WRITE, d, 1'b0);
    check(8'(rack), 8'(e));
  endtask : send

  task automatic fetch(input logic a, input logic [7:0] e);
    cmd(twe_pkg::CMD_READ, 8'h00, a);
    check(rdat, e);
  endtask : fetch

  task automatic point(input logic [7:0] a);
    bus_start();
    send(DEV, 1'b1);
    send(a, 1'b1);
  endtask : point

  task automatic open_read;
    bus_start();
    send(DEV | 8'h01, 1'b1);
  endtask : open_read

  // Stop, then poll until the self-timed write is over
  task automatic finish_write(input logic prot);
    int n;
    bus_stop();
    check(8'(busy), 8'(!prot));
    bus_start();
    send(DEV, prot);
    n = 0;
    while (rack !== 1'b1 && n < 6) begin
      bus_start();
      cmd(twe_pkg::CMD_WRITE, DEV, 1'b0);
      n++;
    end
    check(8'(rack), 8'h01);
    bus_stop();
  endtask : finish_write

  task automatic store(input logic [7:0] a, input logic [7:0] d,
      input logic prot);
    point(a);
    send(d, 1'b1);
    finish_write(prot);
  endtask : store

  task automatic addressing;
    int i;
    for (i = 0; i < 8; i++) begin
      bus_start();
      send({4'hA, i[2:0], 1'b0}, i[2:0] == SEL);
    end
    bus_start();
    send({4'h5, SEL, 1'b0}, 1'b0);
    @(posedge mclk);
    straps <= 3'h2;
    bus_start();
    send(8'hA4, 1'b1);
    bus_stop();
    @(posedge mclk);
    straps <= SEL;
  endtask : addressing

  task automatic byte_write;
    store(8'h10, 8'h5A, 1'b0);
    point(8'h10);
    open_read();
    fetch(1'b0, 8'h5A);
    bus_stop();
  endtask : byte_write

  // Eighteen bytes into one page, so the last two overwrite
  task automatic page_write;
    int i;
    logic [4:0] k;
    point(8'h2E);
    for (i = 0; i < 18; i++) begin
      send(8'h80 + 8'(i), 1'b1);
    end
    finish_write(1'b0);
    point(8'h20);
    for (i = 0; i < 16; i++) begin
      if (i % 8 == 0) begin
        open_read();
      end
      k = 5'((i + 2) % 16);
      if (k < 5'h02) begin
        k = k + 5'h10;
      end
      fetch(i % 8 != 7, 8'h80 + 8'(k));
      if (i % 8 == 7) begin
        bus_stop();
      end
    end
  endtask : page_write

  task automatic read_wrap;
    store(8'hFF, 8'hC3, 1'b0);
    store(8'h00, 8'h3C, 1'b0);
    point(8'hFF);
    open_read();
    fetch(1'b1, 8'hC3);
    fetch(1'b0, 8'h3C);
    bus_stop();
    point(8'hFF);
    open_read();
    fetch(1'b1, 8'hC3);
    // Memory now pulls data low for the next byte
    cmd(twe_pkg::CMD_RECOVER, 8'h00, 1'b0);
    check(8'(rack), 8'h01);
    bus_start();
    send(DEV, 1'b1);
    bus_stop();
  endtask : read_wrap

  task automatic protect;
    @(posedge mclk);
    wp <= 1'b1;
    store(8'h10, 8'hFF, 1'b1);
    @(posedge mclk);
    wp <= 1'b0;
    point(8'h10);
    open_read();
    fetch(1'b0, 8'h5A);
    bus_stop();
  endtask : protect

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    addressing();
    byte_write();
    page_write();
    read_wrap();
    protect();
    complete_run();
  end
endmodule : tb_top
